// File: rtl/cals_pkg.sv
// Shared constants and types for the card application list selection sequencer
package cals_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int AID_N = 8;
    localparam int CAND_N = 4;
    localparam int NAME_W = 128;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_HOLDER = 8'h08;
    localparam logic [7:0] A_AIDW0 = 8'h10;
    localparam logic [7:0] A_AIDW3 = 8'h1c;
    localparam logic [7:0] A_AIDCMT = 8'h20;
    localparam logic [7:0] A_CAND0 = 8'h40;
    localparam logic [7:0] A_CAND3 = 8'h4c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_START = 0;
    localparam int CTRL_DIR_OK = 1;
    localparam int CTRL_DIR_FOUND = 2;
    localparam int CTRL_CONF_CAP = 3;
    localparam int CTRL_AUTO = 4;
    localparam int CTRL_CNT_LSB = 8;
    localparam int HOLD_APPROVE = 0;
    localparam int HOLD_DECLINE = 1;
    localparam int HOLD_RANK_LSB = 4;
    localparam int HOLD_CHOOSE = 8;
    localparam int CMT_LEN_LSB = 0;
    localparam int CMT_PREFIX = 8;
    localparam int CMT_IDX_LSB = 16;
    localparam int API_CONF = 7;
    localparam int API_PRIO_LSB = 0;
    localparam int STAT_CNT_LSB = 12;
    localparam int STAT_OVF = 16;
    localparam int STAT_NEED_CONF = 17;
    localparam int STAT_DONE = 18;
    localparam int STAT_TERM = 19;
    localparam int STAT_PICK_LSB = 20;

    // ------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------
    localparam logic [15:0] SW_OK = 16'h9000;
    localparam logic [15:0] SW_APP_BLOCKED = 16'h6283;
    localparam logic [15:0] SW_CARD_BLOCKED = 16'h6a81;
    localparam logic [7:0] P2_FIRST = 8'h00;
    localparam logic [7:0] P2_NEXT = 8'h02;
    localparam logic [3:0] PRIO_NONE = 4'h0;
    localparam logic [4:0] PRIO_KEY_NONE = 5'h10;

    typedef enum logic [9:0] {
        ST_IDLE = 10'h001,
        ST_SEL = 10'h002,
        ST_WAIT = 10'h004,
        ST_FCHK = 10'h008,
        ST_CONF = 10'h010,
        ST_CHOOSE = 10'h020,
        ST_FSEL = 10'h040,
        ST_FWAIT = 10'h080,
        ST_DONE = 10'h100,
        ST_TERM = 10'h200
    } cals_state_t;

    typedef struct packed {
        logic [NAME_W-1:0] name;
        logic [4:0] len;
        logic prefix;
    } cals_aid_t;

    typedef struct packed {
        logic [NAME_W-1:0] name;
        logic [4:0] len;
        logic [7:0] api;
    } cals_cand_t;

    typedef struct packed {
        logic req;
        logic final_sel;
        logic [7:0] p2;
        logic [4:0] len;
        logic [NAME_W-1:0] name;
    } cals_sel_cmd_t;

    typedef struct packed {
        logic valid;
        logic [15:0] sw;
        logic [4:0] len;
        logic [NAME_W-1:0] name;
        logic [7:0] api;
    } cals_card_rsp_t;

    typedef struct packed {
        cals_state_t state;
        logic [15:0] ctrl;
        logic [3:0][31:0] stage;
        cals_aid_t [AID_N-1:0] aid;
        cals_cand_t [CAND_N-1:0] cand;
        logic [2:0] aid_idx;
        logic next;
        logic [2:0] cand_cnt;
        logic [1:0] pick;
        logic ovf;
        logic need_conf;
        logic by_holder;
        cals_sel_cmd_t sel;
        logic [31:0] rdata;
        logic done;
        logic term;
    } cals_st_t;

    localparam cals_st_t ST_RESET = '{state: ST_IDLE, default: '0};
endpackage

// File: rtl/cals_core.sv
// Terminal application list walk and final selection sequencer
// Summary of operation
// RULE1: Walk own identifier list when directory unsupported or yielded nothing.
// RULE2: First SELECT names the first identifier in the terminal list.
// RULE3: Status 6A81 on a list SELECT ends the card session.
// RULE4: On 9000 or 6283 classify returned name as exact or partial match.
// RULE5: Card returns name equal to identifier, or longer and starting with it.
// RULE6: Exact match with 9000 appends the entry, then advances.
// RULE7: Exact match with 6283 adds nothing, then advances.
// RULE8: Any other status skips to the next identifier.
// RULE9: Advance issues next SELECT; list end starts final selection.
// RULE10: Partial match with single occurrence allowed adds nothing, issues select-next.
// RULE11: Partial match, multiple allowed: add only on 9000, always select-next.
// RULE12: Select-next repeats same name with P2 set to 02.
// RULE13: Each entry keeps card name and priority byte.
// RULE14: Empty list at final selection terminates.
// RULE15: Single entry: b8 clear selects, b8 set needs approval else terminate.
// RULE16: Automatic choice takes highest priority, skipping b8 entries without confirmation.
// RULE17: Offered list is in priority order, ties in encounter order.
// RULE18: Final SELECT uses the name returned by the card.
// RULE19: Final SELECT other than 9000 removes entry, restarts at empty check.
// RULE20: After a chosen or confirmed entry is removed, confirmation is always required.
// RULE21: Priority byte: b8 confirm, b4-b1 priority, zero means none, 1 highest.
// RULE22: Each identifier stores its matching criterion, exact or prefix.
// RULE23: Candidate store has fixed capacity; extra entries dropped, overflow flagged.
module cals_core
    import cals_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Card command link
    output cals_sel_cmd_t sel_cmd,
    input wire cals_card_rsp_t card_rsp,
    // Outcome
    output logic app_selected,
    output logic session_end
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic rst_n;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    cals_st_t s_r;
    cals_st_t s_nxt;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [4:0] prio_key(input logic [7:0] api);
        if (api[API_PRIO_LSB+:4] == PRIO_NONE) begin // RULE21
            return PRIO_KEY_NONE;
        end
        return {1'b0, api[API_PRIO_LSB+:4]};
    endfunction

    function automatic logic [1:0] rank_of(input cals_cand_t [CAND_N-1:0] c, input logic [2:0] cnt, input int j);
        logic [4:0] kj;
        logic [4:0] kk;
        logic [1:0] r;
        r = 2'h0;
        kj = prio_key(c[j].api);
        for (int k = 0; k < CAND_N; k++) begin
            kk = prio_key(c[k].api);
            if (k < int'(cnt) && (kk < kj || (kk == kj && k < j))) begin // RULE17
                r = r + 2'h1;
            end
        end
        return r;
    endfunction

    function automatic logic [1:0] at_rank(input cals_cand_t [CAND_N-1:0] c, input logic [2:0] cnt,
                                           input logic [1:0] r);
        logic [1:0] idx;
        idx = 2'h0;
        for (int j = 0; j < CAND_N; j++) begin
            if (j < int'(cnt) && rank_of(c, cnt, j) == r) begin
                idx = 2'(j);
            end
        end
        return idx;
    endfunction

    function automatic logic [NAME_W-1:0] name_mask(input logic [4:0] len);
        return ~({NAME_W{1'b1}} >> {len, 3'h0});
    endfunction

    // Match of the returned name against the current identifier
    cals_aid_t cur_aid;
    logic prefix_eq;
    logic exact_m;
    logic part_m;
    logic sw_ok;
    logic sw_blk;
    logic sw_card_blk;
    assign cur_aid = s_r.aid[s_r.aid_idx];
    assign prefix_eq = ((card_rsp.name ^ cur_aid.name) & name_mask(cur_aid.len)) == '0;
    assign exact_m = prefix_eq && card_rsp.len == cur_aid.len; // RULE4
    assign part_m = prefix_eq && card_rsp.len > cur_aid.len; // RULE4
    assign sw_ok = card_rsp.sw == SW_OK;
    assign sw_blk = card_rsp.sw == SW_APP_BLOCKED;
    assign sw_card_blk = card_rsp.sw == SW_CARD_BLOCKED;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic advance;
        logic add;
        logic best_found;
        logic [1:0] best_idx;
        logic [1:0] best_rank;
        logic [1:0] r;
        logic start;
        logic conf_cap;
        logic [1:0] hold_rank;
        advance = 1'b0;
        add = 1'b0;
        best_found = 1'b0;
        best_idx = 2'h0;
        best_rank = 2'h0;
        r = 2'h0;
        s_nxt = s_r;
        s_nxt.sel.req = 1'b0;
        s_nxt.rdata = 32'h0;
        start = reg_wr && reg_addr == A_CTRL && reg_wdata[CTRL_START];
        conf_cap = s_r.ctrl[CTRL_CONF_CAP];
        hold_rank = reg_wdata[HOLD_RANK_LSB+:2];

        // Register writes
        if (reg_wr) begin
            if (reg_addr == A_CTRL) begin
                s_nxt.ctrl = {reg_wdata[15:1], 1'b0};
            end
            if (reg_addr >= A_AIDW0 && reg_addr <= A_AIDW3) begin
                s_nxt.stage[3 - int'(reg_addr[3:2])] = reg_wdata;
            end
            if (reg_addr == A_AIDCMT) begin
                s_nxt.aid[reg_wdata[CMT_IDX_LSB+:3]].name = s_r.stage;
                s_nxt.aid[reg_wdata[CMT_IDX_LSB+:3]].len = reg_wdata[CMT_LEN_LSB+:5];
                s_nxt.aid[reg_wdata[CMT_IDX_LSB+:3]].prefix = reg_wdata[CMT_PREFIX]; // RULE22
            end
        end

        // Register reads, answered in the next cycle
        if (reg_rd) begin
            if (reg_addr == A_CTRL) begin
                s_nxt.rdata = {16'h0, s_r.ctrl};
            end else if (reg_addr == A_STAT) begin
                s_nxt.rdata = {10'h0, s_r.pick, s_r.term, s_r.done, s_r.need_conf, s_r.ovf,
                               1'b0, s_r.cand_cnt, 2'h0, s_r.state};
            end else if (reg_addr >= A_CAND0 && reg_addr <= A_CAND3) begin
                r = reg_addr[3:2];
                if ({1'b0, r} < s_r.cand_cnt) begin // RULE17
                    s_nxt.rdata = {15'h0, 1'b1, 3'h0, s_r.cand[at_rank(s_r.cand, s_r.cand_cnt, r)].len,
                                   s_r.cand[at_rank(s_r.cand, s_r.cand_cnt, r)].api};
                end
            end
        end

        unique case (s_r.state)
            ST_IDLE, ST_DONE, ST_TERM: begin
                if (start) begin
                    s_nxt.cand_cnt = 3'h0;
                    s_nxt.ovf = 1'b0;
                    s_nxt.need_conf = 1'b0;
                    s_nxt.by_holder = 1'b0;
                    s_nxt.done = 1'b0;
                    s_nxt.term = 1'b0;
                    s_nxt.aid_idx = 3'h0;
                    s_nxt.next = 1'b0;
                    if (!reg_wdata[CTRL_DIR_OK] || !reg_wdata[CTRL_DIR_FOUND]) begin // RULE1
                        s_nxt.state = (reg_wdata[CTRL_CNT_LSB+:4] == 4'h0) ? ST_FCHK : ST_SEL;
                    end else begin
                        s_nxt.state = ST_IDLE;
                    end
                end
            end
            ST_SEL: begin
                s_nxt.sel.req = 1'b1; // RULE2
                s_nxt.sel.final_sel = 1'b0;
                s_nxt.sel.name = cur_aid.name;
                s_nxt.sel.len = cur_aid.len;
                s_nxt.sel.p2 = s_r.next ? P2_NEXT : P2_FIRST; // RULE12
                s_nxt.state = ST_WAIT;
            end
            ST_WAIT: begin
                if (card_rsp.valid) begin
                    if (sw_card_blk) begin
                        s_nxt.state = ST_TERM; // RULE3
                        s_nxt.term = 1'b1;
                    end else if ((sw_ok || sw_blk) && exact_m) begin
                        add = sw_ok; // RULE6 RULE7
                        advance = 1'b1;
                    end else if ((sw_ok || sw_blk) && part_m) begin
                        add = cur_aid.prefix && sw_ok; // RULE10 RULE11
                        s_nxt.next = 1'b1; // RULE12
                        s_nxt.state = ST_SEL;
                    end else begin
                        advance = 1'b1; // RULE8
                    end
                end
            end
            ST_FCHK: begin
                if (s_r.cand_cnt == 3'h0) begin
                    s_nxt.state = ST_TERM; // RULE14
                    s_nxt.term = 1'b1;
                end else if (s_r.cand_cnt == 3'h1) begin
                    s_nxt.pick = 2'h0;
                    if (!s_r.cand[0].api[API_CONF] && !s_r.need_conf) begin // RULE15 RULE20
                        s_nxt.state = ST_FSEL;
                    end else if (conf_cap) begin
                        s_nxt.state = ST_CONF;
                    end else begin
                        s_nxt.state = ST_TERM;
                        s_nxt.term = 1'b1;
                    end
                end else if (s_r.ctrl[CTRL_AUTO] && !s_r.need_conf) begin
                    for (int j = 0; j < CAND_N; j++) begin
                        r = rank_of(s_r.cand, s_r.cand_cnt, j);
                        if (j < int'(s_r.cand_cnt) && (!s_r.cand[j].api[API_CONF] || conf_cap)
                            && (!best_found || r < best_rank)) begin // RULE16
                            best_found = 1'b1;
                            best_rank = r;
                            best_idx = 2'(j);
                        end
                    end
                    s_nxt.pick = best_idx;
                    s_nxt.state = best_found ? ST_FSEL : ST_TERM;
                    s_nxt.term = !best_found;
                end else if (conf_cap || !s_r.need_conf) begin
                    s_nxt.state = ST_CHOOSE; // RULE20
                end else begin
                    s_nxt.state = ST_TERM;
                    s_nxt.term = 1'b1;
                end
            end
            ST_CONF: begin
                if (reg_wr && reg_addr == A_HOLDER && reg_wdata[HOLD_APPROVE]) begin // RULE15
                    s_nxt.by_holder = 1'b1;
                    s_nxt.state = ST_FSEL;
                end else if (reg_wr && reg_addr == A_HOLDER && reg_wdata[HOLD_DECLINE]) begin
                    s_nxt.state = ST_TERM;
                    s_nxt.term = 1'b1;
                end
            end
            ST_CHOOSE: begin
                if (reg_wr && reg_addr == A_HOLDER && reg_wdata[HOLD_CHOOSE]
                    && {1'b0, hold_rank} < s_r.cand_cnt) begin // RULE17
                    s_nxt.pick = at_rank(s_r.cand, s_r.cand_cnt, hold_rank);
                    s_nxt.by_holder = 1'b1;
                    s_nxt.state = ST_FSEL;
                end else if (reg_wr && reg_addr == A_HOLDER && reg_wdata[HOLD_DECLINE]) begin
                    s_nxt.state = ST_TERM;
                    s_nxt.term = 1'b1;
                end
            end
            ST_FSEL: begin
                s_nxt.sel.req = 1'b1;
                s_nxt.sel.final_sel = 1'b1;
                s_nxt.sel.name = s_r.cand[s_r.pick].name; // RULE18
                s_nxt.sel.len = s_r.cand[s_r.pick].len;
                s_nxt.sel.p2 = P2_FIRST;
                s_nxt.state = ST_FWAIT;
            end
            ST_FWAIT: begin
                if (card_rsp.valid) begin
                    if (sw_ok) begin
                        s_nxt.state = ST_DONE;
                        s_nxt.done = 1'b1;
                    end else begin
                        for (int i = 0; i < CAND_N - 1; i++) begin // RULE19
                            if (i >= int'(s_r.pick)) begin
                                s_nxt.cand[i] = s_r.cand[i + 1];
                            end
                        end
                        s_nxt.cand[CAND_N-1] = '0;
                        s_nxt.cand_cnt = s_r.cand_cnt - 3'h1;
                        s_nxt.need_conf = s_r.need_conf || s_r.by_holder; // RULE20
                        s_nxt.by_holder = 1'b0;
                        s_nxt.state = ST_FCHK;
                    end
                end
            end
            default: begin
                s_nxt.state = ST_IDLE;
            end
        endcase

        if (add) begin
            if (s_r.cand_cnt < 3'(CAND_N)) begin
                s_nxt.cand[s_r.cand_cnt[1:0]].name = card_rsp.name; // RULE13
                s_nxt.cand[s_r.cand_cnt[1:0]].len = card_rsp.len;
                s_nxt.cand[s_r.cand_cnt[1:0]].api = card_rsp.api;
                s_nxt.cand_cnt = s_r.cand_cnt + 3'h1;
            end else begin
                s_nxt.ovf = 1'b1; // RULE23
            end
        end
        if (advance) begin
            s_nxt.next = 1'b0;
            if ({1'b0, s_r.aid_idx} + 4'h1 >= s_r.ctrl[CTRL_CNT_LSB+:4]) begin // RULE9
                s_nxt.state = ST_FCHK;
            end else begin
                s_nxt.aid_idx = s_r.aid_idx + 3'h1;
                s_nxt.state = ST_SEL;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= ST_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata = s_r.rdata;
    assign sel_cmd = s_r.sel;
    assign app_selected = s_r.done;
    assign session_end = s_r.term;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence seq_list_rsp;
        s_r.state == ST_WAIT && card_rsp.valid;
    endsequence

    sequence seq_partial;
        seq_list_rsp and (sw_ok || sw_blk) && part_m && !exact_m;
    endsequence

    AST_CARD_BLOCK: assert property (seq_list_rsp and sw_card_blk |=> s_r.state == ST_TERM && session_end) // RULE3
        else $error("card blocked status did not end session");
    AST_FIRST_SEL: assert property (s_r.state == ST_IDLE && reg_wr && reg_addr == A_CTRL && reg_wdata[CTRL_START]
        && !reg_wdata[CTRL_DIR_OK] && reg_wdata[CTRL_CNT_LSB+:4] != 4'h0
        |=> ##1 sel_cmd.req && sel_cmd.p2 == P2_FIRST && sel_cmd.name == s_r.aid[0].name) // RULE2
        else $error("first select did not use first identifier");
    AST_ADD_EXACT: assert property (seq_list_rsp and sw_ok && exact_m && s_r.cand_cnt < 3'h4
        |=> s_r.cand_cnt == $past(s_r.cand_cnt) + 3'h1) // RULE6
        else $error("exact match was not added");
    AST_BLOCKED_NOADD: assert property (seq_list_rsp and sw_blk && exact_m
        |=> s_r.cand_cnt == $past(s_r.cand_cnt) && !s_r.next && (s_r.state == ST_SEL || s_r.state == ST_FCHK)) // RULE7
        else $error("blocked application was added");
    AST_SELECT_NEXT: assert property (seq_partial |=> ##1 sel_cmd.req && sel_cmd.p2 == P2_NEXT
        && sel_cmd.name == $past(cur_aid.name, 2)) // RULE12
        else $error("partial match did not issue select next");
    AST_SINGLE_NOADD: assert property (seq_partial and !cur_aid.prefix |=> s_r.cand_cnt == $past(s_r.cand_cnt)) // RULE10
        else $error("single occurrence partial match added");
    AST_OTHER_SKIP: assert property (seq_list_rsp and !sw_ok && !sw_blk && !sw_card_blk
        |=> !s_r.next && (s_r.state == ST_SEL || s_r.state == ST_FCHK)) // RULE8
        else $error("other status did not skip");
    AST_EMPTY_TERM: assert property (s_r.state == ST_FCHK && s_r.cand_cnt == 3'h0 |=> session_end) // RULE14
        else $error("empty list did not terminate");
    AST_SINGLE_B8: assert property (s_r.state == ST_FCHK && s_r.cand_cnt == 3'h1 && s_r.cand[0].api[API_CONF]
        && !s_r.ctrl[CTRL_CONF_CAP] |=> s_r.state == ST_TERM) // RULE15
        else $error("confirmation needed without capability");
    AST_FINAL_FAIL: assert property (s_r.state == ST_FWAIT && card_rsp.valid && !sw_ok
        |=> s_r.state == ST_FCHK && s_r.cand_cnt == $past(s_r.cand_cnt) - 3'h1) // RULE19
        else $error("failed final select not removed");
    AST_OVERFLOW: assert property (seq_list_rsp and sw_ok && exact_m && s_r.cand_cnt == 3'h4 |=> s_r.ovf) // RULE23
        else $error("overflow not flagged");
endmodule

// File: dv/cals_card_model.sv
// Card model answering SELECT commands from a queued plan
module cals_card_model
    import cals_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Card link
    input wire cals_sel_cmd_t sel_cmd,
    output cals_card_rsp_t card_rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] plan_q[$];
    cals_sel_cmd_t cmd;
    cals_card_rsp_t r;
    logic [31:0] p;
    int wait_n = 0;
    initial card_rsp = '0;
    task push(input logic [15:0] sw, input logic [7:0] api, input logic part);
        plan_q.push_back({sw, api, 7'h0, part});
    endtask
    // Idle lines show the inverse of the last value
    always @(posedge mclk) begin
        r = '{valid: 1'b0, sw: ~card_rsp.sw, len: ~card_rsp.len, name: ~card_rsp.name, api: ~card_rsp.api};
        if (sel_cmd.req === 1'b1) begin
            cmd = sel_cmd;
            wait_n = 2;
        end else if (wait_n > 0) begin
            wait_n = wait_n - 1;
            if (wait_n == 0) begin
                p = (plan_q.size() > 0) ? plan_q.pop_front() : 32'h6a820000;
                r.valid = 1'b1;
                r.sw = p[31:16];
                r.api = p[15:8];
                r.len = cmd.len + 5'(p[0]);
                r.name = p[0] ? (cmd.name | (128'hee << (120 - 8 * cmd.len))) : cmd.name;
            end
        end
        card_rsp <= r;
    end
endmodule

// File: dv/tb_cals_core.sv
// Self-checking bench for the list walk and final selection sequencer
module tb_cals_core;
    import cals_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0;
    logic nrst = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 0;
    logic reg_rd = 0;
    logic [31:0] reg_rdata;
    logic [31:0] d;
    cals_sel_cmd_t sel_cmd;
    cals_card_rsp_t card_rsp;
    logic app_selected;
    logic session_end;
    cals_sel_cmd_t log_q[$];
    int errors = 0;
    int total_checks = 0;
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) if (sel_cmd.req === 1'b1) log_q.push_back(sel_cmd);
    cals_core cals_core_inst (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sel_cmd(sel_cmd), .card_rsp(card_rsp),
        .app_selected(app_selected), .session_end(session_end));
    cals_card_model cals_card_model_inst (.mclk(mclk), .sel_cmd(sel_cmd), .card_rsp(card_rsp));
    // ------------------------------------------------------------
    // Common tasks
    // ------------------------------------------------------------
    task wrap_up();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk) begin reg_wr <= 1; reg_addr <= a; reg_wdata <= v; end
        @(posedge mclk) reg_wr <= 0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge mclk) begin reg_rd <= 1; reg_addr <= a; end
        @(posedge mclk) reg_rd <= 0;
        #1 d = reg_rdata;
    endtask
    function automatic logic [127:0] aidn(input int k);
        return {32'ha0000000, 8'(k + 1), 88'h0};
    endfunction
    task rst();
        @(posedge mclk) nrst <= 0;
        repeat (4) @(posedge mclk);
        nrst <= 1;
        repeat (3) @(posedge mclk);
        log_q.delete();
    endtask
    task load(input int k, input logic pre);
        logic [127:0] n;
        n = aidn(k);
        for (int w = 0; w < 4; w++) wr(A_AIDW0 + 8'(4 * w), n[127 - 32 * w -: 32]);
        wr(A_AIDCMT, {13'h0, 3'(k), 7'h0, pre, 8'h05});
    endtask
    task go(input logic [3:0] cnt, input logic [7:0] flags);
        wr(A_CTRL, {20'h0, cnt, flags | 8'h01});
        fin();
    endtask
    task fin();
        int i;
        for (i = 0; i < 300 && app_selected !== 1'b1 && session_end !== 1'b1; i++) @(posedge mclk);
        #1;
        if (i == 300) begin
            errors++;
            wrap_up();
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task sc_exact();
        rst();
        load(0, 0);
        cals_card_model_inst.push(SW_OK, 8'h01, 0);
        cals_card_model_inst.push(SW_OK, 8'h00, 0);
        go(1, 8'h00);
        chk("selected", app_selected, 1);
        chk("first p2", log_q[0].p2, P2_FIRST);
        chk("first name", log_q[0].name[127:96], 32'ha0000000);
        chk("final kind", log_q[1].final_sel, 1);
        chk("final name", log_q[1].name[95:64], 32'h01000000);
        rd(A_CAND0);
        chk("cand0", d[16:0], 17'h10501);
    endtask
    task sc_blocked();
        rst();
        load(0, 0);
        wr(A_CTRL, 32'h107);
        repeat (10) @(posedge mclk);
        chk("dir used", log_q.size(), 0);
        cals_card_model_inst.push(SW_CARD_BLOCKED, 8'h00, 0);
        go(1, 8'h02);
        chk("ended", session_end, 1);
        chk("selects", log_q.size(), 1);
    endtask
    task sc_walk();
        rst();
        load(0, 0);
        load(1, 1);
        cals_card_model_inst.push(SW_APP_BLOCKED, 8'h00, 0);
        cals_card_model_inst.push(SW_OK, 8'h81, 1);
        cals_card_model_inst.push(16'h6a82, 8'h00, 0);
        go(2, 8'h00);
        chk("ended", session_end, 1);
        chk("selects", log_q.size(), 3);
        chk("second", log_q[1].name[95:88], 8'h02);
        chk("next p2", log_q[2].p2, P2_NEXT);
        chk("next name", log_q[2].name[95:88], 8'h02);
        rd(A_STAT);
        chk("count", d[14:12], 1);
        rd(A_CAND0);
        chk("cand0", d[16:0], 17'h10681);
    endtask
    task sc_empty();
        rst();
        load(0, 0);
        go(1, 8'h00);
        chk("ended", session_end, 1);
        chk("selects", log_q.size(), 1);
    endtask
    task sc_auto();
        rst();
        for (int k = 0; k < 5; k++) load(k, 0);
        cals_card_model_inst.push(SW_OK, 8'h02, 0);
        cals_card_model_inst.push(SW_OK, 8'h01, 0);
        cals_card_model_inst.push(SW_OK, 8'h81, 0);
        cals_card_model_inst.push(SW_OK, 8'h00, 0);
        cals_card_model_inst.push(SW_OK, 8'h00, 0);
        cals_card_model_inst.push(16'h6a82, 8'h00, 0);
        cals_card_model_inst.push(SW_OK, 8'h00, 0);
        go(5, 8'h10);
        chk("selected", app_selected, 1);
        chk("pick", log_q[5].name[95:88], 8'h02);
        chk("retry", log_q[6].name[95:88], 8'h01);
        rd(A_STAT);
        chk("count", d[14:12], 3);
        chk("overflow", d[16], 1);
        rd(A_CAND0);
        chk("rank0", d[7:0], 8'h81);
        rd(A_CAND0 + 8'h04);
        chk("rank1", d[7:0], 8'h02);
    endtask
    task hold(input logic [9:0] st, input logic [31:0] v);
        d = 32'h0;
        for (int i = 0; i < 60 && d[9:0] != st; i++) rd(A_STAT);
        chk("holder state", d[9:0], 32'(st));
        wr(A_HOLDER, v);
    endtask
    task sc_holder();
        rst();
        load(0, 0);
        load(1, 0);
        cals_card_model_inst.push(SW_OK, 8'h81, 0);
        cals_card_model_inst.push(SW_OK, 8'h02, 0);
        cals_card_model_inst.push(16'h6a82, 8'h00, 0);
        cals_card_model_inst.push(SW_OK, 8'h00, 0);
        wr(A_CTRL, 32'h209);
        hold(10'h020, 32'h100);
        hold(10'h010, 32'h1);
        fin();
        chk("selected", app_selected, 1);
        chk("chosen", log_q[2].name[95:88], 8'h01);
        chk("confirmed", log_q[3].name[95:88], 8'h02);
    endtask
    initial begin
        sc_exact();
        sc_blocked();
        sc_walk();
        sc_empty();
        sc_auto();
        sc_holder();
        wrap_up();
    end
endmodule
